/* File: pkg/uhc_pkg.sv */
// Shared constants for the host channel condition and interrupt enable block
package uhc_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CHAN_STATUS   = 9'h14A;
   localparam logic [ADDR_W-1:0] OFS_SIE_ENABLE_0  = 9'h150;
   localparam logic [ADDR_W-1:0] OFS_SIE_ENABLE_1  = 9'h151;
   localparam logic [ADDR_W-1:0] OFS_RESERVED_SLOT = 9'h152;
   localparam logic [ADDR_W-1:0] OFS_FRAME_ENABLE  = 9'h153;
   localparam logic [ADDR_W-1:0] OFS_CHAN_ENABLE   = 9'h15A;
   localparam logic [ADDR_W-1:0] OFS_COMPLETION    = 9'h160;
   localparam logic [ADDR_W-1:0] OFS_SUMMARY       = 9'h161;
   localparam logic [ADDR_W-1:0] OFS_SIE_STATUS_0  = 9'h162;
   localparam logic [ADDR_W-1:0] OFS_SIE_STATUS_1  = 9'h163;
   localparam logic [ADDR_W-1:0] OFS_FRAME_STATUS  = 9'h164;

   // Writable field masks; everything else reads zero
   localparam logic [DATA_W-1:0] MASK_SIE_0  = 8'h1F;
   localparam logic [DATA_W-1:0] MASK_SIE_1  = 8'h0F;
   localparam logic [DATA_W-1:0] MASK_FRAME  = 8'h07;
   localparam logic [DATA_W-1:0] MASK_CHAN   = 8'h10;
   localparam logic [DATA_W-1:0] REG_RESET   = 8'h00;

   // Field positions
   localparam int unsigned BIT_COND_CHANGE = 4;
   localparam int unsigned SUM_SIE_0       = 0;
   localparam int unsigned SUM_SIE_1       = 1;
   localparam int unsigned SUM_FRAME       = 2;
   localparam int unsigned SUM_CHAN        = 3;
   localparam int unsigned SUM_W           = 4;

   // Completion codes
   localparam logic [2:0] CODE_CLEAN_COMPLETION = 3'h0;
   localparam logic [2:0] CODE_STALL            = 3'h1;
   localparam logic [2:0] CODE_OVERRUN          = 3'h2;
   localparam logic [2:0] CODE_UNDERRUN         = 3'h3;
   localparam logic [2:0] CODE_RETRY_FAULT      = 3'h4;

   // Consecutive-event limits
   localparam logic [1:0] RETRY_LIMIT = 2'h3;
   localparam logic [1:0] NYET_LIMIT  = 2'h3;

endpackage

/* File: core/uhc_irq_enable.sv */
// Host channel completion classifier, status/enable registers and interrupt summary
//
// How it works
// - Stall, overrun, underrun or three retry faults in a row set condition_change_flag.
// - Firmware clearing transfer_go also sets the flag; completion code keeps last result.
// - Completion code: 000 clean, 001 stall, 010 overrun, 011 underrun, 100 retry.
// - Overrun when packet exceeds max length or received bytes exceed transfer total.
// - CRC or bit-stuff error alongside overrun or underrun becomes a retry fault.
// - Packet within max length with bad toggle is toggle mismatch, not overrun.
// - Underrun when packet is short and received bytes stay below transfer total.
// - No answer to IN, or no handshake after OUT, within timeout is retry fault.
// - CRC, bit-stuff, PID check failure or invalid PID is a retry fault.
// - Interrupt split: ERR handshake or three consecutive NYETs is a retry fault.
// - Data toggle mismatch from the endpoint is a retry fault unless the packet exceeds max length.
// - Enable bit at one lets its status cause raise the group summary bit.
// - Root SIE enable 0 holds five detect enables in bits 4..0, resets zero.
// - Root SIE enable 1 holds four completion enables in bits 3..0, resets zero.
// - Frame enable holds port error, frame wrap, frame start in bits 2..0.
// - Writing one clears a status bit; writing zero leaves it unchanged.
module uhc_irq_enable
   import uhc_pkg::*;
#(
   parameter int unsigned LEN_W = 11,
   parameter int unsigned TOT_W = 16
) (
   // Clock and reset
   input  wire  logic              clk_sys,
   input  wire  logic              reset_n,
   // Register port
   input  wire  logic [ADDR_W-1:0] reg_addr,
   input  wire  logic [DATA_W-1:0] reg_wdata,
   input  wire  logic              reg_wr,
   input  wire  logic              reg_rd,
   output logic       [DATA_W-1:0] reg_rdata,
   // Transaction result from the serial engine
   input  wire  logic              txn_done,
   input  wire  logic              txn_stall,
   input  wire  logic              txn_timeout,
   input  wire  logic              rx_packet,
   input  wire  logic [LEN_W-1:0]  rx_length,
   input  wire  logic [LEN_W-1:0]  max_packet_length,
   input  wire  logic [TOT_W-1:0]  rx_byte_sum,
   input  wire  logic [TOT_W-1:0]  transfer_byte_total,
   input  wire  logic              crc_error,
   input  wire  logic              stuff_error,
   input  wire  logic              pid_check_error,
   input  wire  logic              pid_invalid,
   input  wire  logic              toggle_mismatch,
   input  wire  logic              split_interrupt,
   input  wire  logic              hs_err,
   input  wire  logic              hs_nyet,
   input  wire  logic              transfer_go,
   // Root port and frame events, one-cycle pulses
   input  wire  logic [4:0]        sie_event_0,
   input  wire  logic [3:0]        sie_event_1,
   input  wire  logic [2:0]        frame_event,
   // Results
   output logic [2:0]              completion_code,
   output logic                    condition_change_flag,
   output logic [SUM_W-1:0]        top_level_irq_summary,
   output logic                    irq
);

   // Clear-on-one with set priority over the clear
   function automatic logic [DATA_W-1:0] w1c_update(
      input logic [DATA_W-1:0] cur,
      input logic [DATA_W-1:0] set,
      input logic              clr_en,
      input logic [DATA_W-1:0] clr,
      input logic [DATA_W-1:0] mask
   );
      logic [DATA_W-1:0] keep;
      keep = clr_en ? (cur & ~clr) : cur;
      return (keep | set) & mask;
   endfunction

   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] ofs
   );
      return a == ofs;
   endfunction

   logic [DATA_W-1:0] sie_enable_0_r;
   logic [DATA_W-1:0] sie_enable_1_r;
   logic [DATA_W-1:0] frame_enable_r;
   logic [DATA_W-1:0] chan_enable_r;
   logic [DATA_W-1:0] sie_status_0_r;
   logic [DATA_W-1:0] sie_status_1_r;
   logic [DATA_W-1:0] frame_status_r;
   logic [DATA_W-1:0] chan_status_r;
   logic [2:0]        code_r;
   logic [1:0]        retry_run_r;
   logic [1:0]        nyet_run_r;
   logic              go_prev_r;
   logic [DATA_W-1:0] rdata_r;
   logic [SUM_W-1:0]  summary_r;
   logic              irq_r;

   // Classification of the finished transaction
   logic              len_over;
   logic              sum_over;
   logic              overrun;
   logic              underrun;
   logic              bit_error;
   logic              nyet_third;
   logic              retry_fault;
   logic [2:0]        code_nxt;
   logic [1:0]        retry_run_nxt;
   logic              cond_set;
   logic              go_cleared;
   logic [SUM_W-1:0]  summary_nxt;

   always_comb begin
      len_over    = rx_packet && (rx_length > max_packet_length);
      sum_over    = rx_packet && (rx_byte_sum > transfer_byte_total);
      overrun     = len_over || (sum_over && !toggle_mismatch);
      underrun    = rx_packet && (rx_length < max_packet_length)
                    && (rx_byte_sum < transfer_byte_total);
      bit_error   = crc_error || stuff_error;
      nyet_third  = split_interrupt && hs_nyet && (nyet_run_r == NYET_LIMIT - 2'h1);
      retry_fault = txn_timeout
                    || bit_error || pid_check_error || pid_invalid
                    || (split_interrupt && hs_err) || nyet_third
                    || (toggle_mismatch && !len_over);
      if (retry_fault) begin
         code_nxt = CODE_RETRY_FAULT;
      end else if (txn_stall) begin
         code_nxt = CODE_STALL;
      end else if (overrun) begin
         code_nxt = CODE_OVERRUN;
      end else if (underrun) begin
         code_nxt = CODE_UNDERRUN;
      end else begin
         code_nxt = CODE_CLEAN_COMPLETION;
      end
      retry_run_nxt = retry_fault ? retry_run_r + 2'h1 : 2'h0;
   end

   assign go_cleared = go_prev_r && !transfer_go;
   assign cond_set   = go_cleared
                       || (txn_done && (code_nxt == CODE_STALL || code_nxt == CODE_OVERRUN
                           || code_nxt == CODE_UNDERRUN
                           || (retry_fault && retry_run_nxt == RETRY_LIMIT)));

   // Completion code holds the last result; a transfer_go clear does not disturb it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         code_r <= CODE_CLEAN_COMPLETION;
      end else if (txn_done) begin
         code_r <= code_nxt;
      end
   end

   // Consecutive retry count restarts after any non-retry result or the third fault
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         retry_run_r <= 2'h0;
      end else if (txn_done) begin
         retry_run_r <= (retry_run_nxt == RETRY_LIMIT) ? 2'h0 : retry_run_nxt;
      end
   end

   // NYET run in interrupt splits; any other handshake breaks the run
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         nyet_run_r <= 2'h0;
      end else if (txn_done && split_interrupt) begin
         nyet_run_r <= (hs_nyet && !nyet_third) ? nyet_run_r + 2'h1 : 2'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         go_prev_r <= 1'b0;
      end else begin
         go_prev_r <= transfer_go;
      end
   end

   // Enable registers; reserved bits are masked off at the write
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sie_enable_0_r <= REG_RESET;
         sie_enable_1_r <= REG_RESET;
         frame_enable_r <= REG_RESET;
         chan_enable_r  <= REG_RESET;
      end else if (reg_wr) begin
         if (hit(reg_addr, OFS_SIE_ENABLE_0)) begin
            sie_enable_0_r <= reg_wdata & MASK_SIE_0;
         end
         if (hit(reg_addr, OFS_SIE_ENABLE_1)) begin
            sie_enable_1_r <= reg_wdata & MASK_SIE_1;
         end
         if (hit(reg_addr, OFS_FRAME_ENABLE)) begin
            frame_enable_r <= reg_wdata & MASK_FRAME;
         end
         if (hit(reg_addr, OFS_CHAN_ENABLE)) begin
            chan_enable_r <= reg_wdata & MASK_CHAN;
         end
      end
   end

   // Sticky status registers, cleared by writing one
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sie_status_0_r <= REG_RESET;
         sie_status_1_r <= REG_RESET;
         frame_status_r <= REG_RESET;
         chan_status_r  <= REG_RESET;
      end else begin
         sie_status_0_r <= w1c_update(sie_status_0_r, {3'h0, sie_event_0},
                              reg_wr && hit(reg_addr, OFS_SIE_STATUS_0), reg_wdata,
                              MASK_SIE_0);
         sie_status_1_r <= w1c_update(sie_status_1_r, {4'h0, sie_event_1},
                              reg_wr && hit(reg_addr, OFS_SIE_STATUS_1), reg_wdata,
                              MASK_SIE_1);
         frame_status_r <= w1c_update(frame_status_r, {5'h00, frame_event},
                              reg_wr && hit(reg_addr, OFS_FRAME_STATUS), reg_wdata,
                              MASK_FRAME);
         chan_status_r  <= w1c_update(chan_status_r,
                              DATA_W'({cond_set, 4'h0}),
                              reg_wr && hit(reg_addr, OFS_CHAN_STATUS), reg_wdata,
                              MASK_CHAN);
      end
   end

   // Summary is combinational so a register read sees it in the same cycle
   always_comb begin
      summary_nxt            = '0;
      summary_nxt[SUM_SIE_0] = |(sie_status_0_r & sie_enable_0_r);
      summary_nxt[SUM_SIE_1] = |(sie_status_1_r & sie_enable_1_r);
      summary_nxt[SUM_FRAME] = |(frame_status_r & frame_enable_r);
      summary_nxt[SUM_CHAN]  = |(chan_status_r & chan_enable_r);
   end

   // Output copies of the summary and interrupt lag one cycle to stay registered
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         summary_r <= '0;
         irq_r     <= 1'b0;
      end else begin
         summary_r <= summary_nxt;
         irq_r     <= |summary_nxt;
      end
   end

   // Read data stands for the single cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= REG_RESET;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_SIE_ENABLE_0:  rdata_r <= sie_enable_0_r;
            OFS_SIE_ENABLE_1:  rdata_r <= sie_enable_1_r;
            OFS_RESERVED_SLOT: rdata_r <= REG_RESET;
            OFS_FRAME_ENABLE:  rdata_r <= frame_enable_r;
            OFS_CHAN_ENABLE:   rdata_r <= chan_enable_r;
            OFS_CHAN_STATUS:   rdata_r <= chan_status_r;
            OFS_COMPLETION:    rdata_r <= {5'h00, code_r};
            OFS_SUMMARY:       rdata_r <= {4'h0, summary_nxt};
            OFS_SIE_STATUS_0:  rdata_r <= sie_status_0_r;
            OFS_SIE_STATUS_1:  rdata_r <= sie_status_1_r;
            OFS_FRAME_STATUS:  rdata_r <= frame_status_r;
            default:           rdata_r <= REG_RESET;
         endcase
      end else begin
         rdata_r <= REG_RESET;
      end
   end

   assign reg_rdata             = rdata_r;
   assign completion_code       = code_r;
   assign condition_change_flag = chan_status_r[BIT_COND_CHANGE];
   assign top_level_irq_summary = summary_r;
   assign irq                   = irq_r;

endmodule

/* File: tb/uhc_irq_enable_sva.sv */
// Checker for the condition classifier and interrupt outputs
module uhc_irq_enable_sva
   import uhc_pkg::*;
(
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // Register port
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Transaction result
   input wire logic              txn_done,
   input wire logic              txn_stall,
   input wire logic              txn_timeout,
   input wire logic              crc_error,
   input wire logic              stuff_error,
   input wire logic              pid_check_error,
   input wire logic              pid_invalid,
   input wire logic              toggle_mismatch,
   input wire logic              split_interrupt,
   input wire logic              hs_err,
   input wire logic              hs_nyet,
   input wire logic              transfer_go,
   // Results
   input wire logic [2:0]        completion_code,
   input wire logic              condition_change_flag,
   input wire logic [SUM_W-1:0]  top_level_irq_summary,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic err_any;
   // NYET is lumped in because a third one in a row is a fault too
   assign err_any = txn_timeout | crc_error | stuff_error | pid_check_error | pid_invalid |
                    toggle_mismatch | hs_err | hs_nyet;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside a read answer");
   a_stall_sets_flag: assert property (txn_done && txn_stall && !err_any
      |=> completion_code == CODE_STALL && condition_change_flag)
      else $error("stall not reported");
   a_crc_is_retry: assert property (txn_done && (crc_error || stuff_error)
      |=> completion_code == CODE_RETRY_FAULT)
      else $error("line error not a retry fault");
   a_noreply_retry: assert property (txn_done && (txn_timeout || pid_check_error ||
      pid_invalid || split_interrupt && hs_err) |=> completion_code == CODE_RETRY_FAULT)
      else $error("missing answer not a retry fault");
   a_code_holds: assert property (!txn_done |=> $stable(completion_code))
      else $error("code changed without a transaction");
   a_go_fall_flag: assert property ($fell(transfer_go) |-> ##[1:2] condition_change_flag)
      else $error("go clear did not raise flag");
   a_irq_or_sum: assert property (irq == (|top_level_irq_summary))
      else $error("irq differs from summary");
   a_chan_sum_cause: assert property ($rose(top_level_irq_summary[SUM_CHAN])
      |-> condition_change_flag)
      else $error("channel summary without flag");
endmodule
bind uhc_irq_enable uhc_irq_enable_sva u_sva (
   .clk_sys(clk_sys), .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .txn_done(txn_done), .txn_stall(txn_stall), .txn_timeout(txn_timeout),
   .crc_error(crc_error), .stuff_error(stuff_error), .pid_check_error(pid_check_error),
   .pid_invalid(pid_invalid), .toggle_mismatch(toggle_mismatch),
   .split_interrupt(split_interrupt), .hs_err(hs_err), .hs_nyet(hs_nyet),
   .transfer_go(transfer_go), .completion_code(completion_code),
   .condition_change_flag(condition_change_flag),
   .top_level_irq_summary(top_level_irq_summary), .irq(irq)
);

/* File: tb/tb.sv */
// Register-level bench for the condition and interrupt enable block
module tb
   import uhc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys = 1'b0;
   logic              reset_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [7:0]        reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [7:0]        reg_rdata;
   logic              txn_done = 1'b0;
   logic [10:0]       fl = '0;
   logic [10:0]       rx_length = '0;
   logic [15:0]       rx_byte_sum = '0;
   logic              transfer_go = 1'b0;
   logic [4:0]        sie_event_0 = '0;
   logic [3:0]        sie_event_1 = '0;
   logic [2:0]        frame_event = '0;
   logic [2:0]        completion_code;
   logic              condition_change_flag;
   logic [SUM_W-1:0]  top_level_irq_summary;
   logic              irq;
   int                mismatches = 0;
   int                samples_checked = 0;
   // Row: flags 3, length 3, byte sum 4, code 1, flag 1 hex digits
   localparam logic [47:0] TV [16] = '{48'h0000_0000_0000, 48'h4000_0000_0011,
      48'h1000_4100_4121, 48'h1000_4000_C921, 48'h1000_0A00_3231, 48'h1080_4000_6440,
      48'h1800_4100_4140, 48'h2000_0000_0041, 48'h1400_0A00_3240, 48'h0200_0000_0040,
      48'h0100_0000_0041, 48'h0060_0000_0040, 48'h0000_0000_0000, 48'h0050_0000_0000,
      48'h0050_0000_0000, 48'h0050_0000_0040};
   localparam logic [ADDR_W-1:0] EA [4] = '{9'h150, 9'h151, 9'h152, 9'h153};
   localparam logic [ADDR_W-1:0] SA [3] = '{9'h162, 9'h163, 9'h164};
   localparam logic [7:0] EM [4] = '{8'h1F, 8'h0F, 8'h00, 8'h07};
   always #5 clk_sys = ~clk_sys;
   uhc_irq_enable u_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn_done(txn_done),
      .txn_stall(fl[10]), .txn_timeout(fl[9]), .rx_packet(fl[8]), .rx_length(rx_length),
      .max_packet_length(11'h040), .rx_byte_sum(rx_byte_sum),
      .transfer_byte_total(16'h00C8), .crc_error(fl[7]), .stuff_error(fl[6]),
      .pid_check_error(fl[5]), .pid_invalid(fl[4]), .toggle_mismatch(fl[3]),
      .split_interrupt(fl[2]), .hs_err(fl[1]), .hs_nyet(fl[0]), .transfer_go(transfer_go),
      .sie_event_0(sie_event_0), .sie_event_1(sie_event_1), .frame_event(frame_event),
      .completion_code(completion_code), .condition_change_flag(condition_change_flag),
      .top_level_irq_summary(top_level_irq_summary), .irq(irq)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic txn(input logic [47:0] r);
      @(posedge clk_sys);
      txn_done <= 1'b1;
      fl <= r[46:36];
      rx_length <= r[34:24];
      rx_byte_sum <= r[23:8];
      @(posedge clk_sys);
      txn_done <= 1'b0;
      fl <= '0;
      #1 chk({5'h0, completion_code}, {5'h0, r[6:4]});
      chk({7'h0, condition_change_flag}, {7'h0, r[0]});
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(EA[i], 8'h00);
         wr(EA[i], 8'hFF);
         rd(EA[i], EM[i]);
      end
      wr(9'h1F0, 8'hFF);
      rd(9'h1F0, 8'h00);
      for (int i = 0; i < 16; i++) begin
         wr(OFS_CHAN_STATUS, 8'h10);
         txn(TV[i]);
      end
      wr(OFS_CHAN_STATUS, 8'h10);
      @(posedge clk_sys) transfer_go <= 1'b1;
      @(posedge clk_sys) transfer_go <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk({7'h0, condition_change_flag}, 8'h01);
      chk({5'h0, completion_code}, 8'h04);
      // Enable written after the cause is pending: summary must follow one cycle after the write
      for (int g = 0; g < 3; g++) begin
         wr(EA[g + g / 2], 8'h00);
         @(posedge clk_sys);
         case (g)
            0: sie_event_0 <= EM[0][4:0];
            1: sie_event_1 <= EM[1][3:0];
            default: frame_event <= EM[3][2:0];
         endcase
         @(posedge clk_sys);
         {sie_event_0, sie_event_1, frame_event} <= '0;
         repeat (2) @(posedge clk_sys);
         #1 chk({4'h0, top_level_irq_summary}, 8'h00);
         rd(SA[g], EM[g + g / 2]);
         wr(EA[g + g / 2], 8'hFF);
         @(posedge clk_sys);
         #1 chk({4'h0, top_level_irq_summary}, 8'h01 << g);
         chk({7'h0, irq}, 8'h01);
         wr(SA[g], 8'h01);
         rd(SA[g], EM[g + g / 2] & 8'hFE);
         wr(SA[g], 8'hFF);
         @(posedge clk_sys);
         #1 chk({7'h0, irq}, 8'h00);
      end
      wr(OFS_CHAN_ENABLE, 8'hFF);
      @(posedge clk_sys);
      #1 chk({4'h0, top_level_irq_summary}, 8'h08);
      wr(OFS_CHAN_STATUS, 8'h10);
      rd(OFS_CHAN_STATUS, 8'h00);
      chk({7'h0, irq}, 8'h00);
      @(posedge clk_sys) reset_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(OFS_FRAME_ENABLE, 8'h00);
      rd(OFS_SIE_ENABLE_1, 8'h00);
      tally_and_finish();
   end
endmodule
